// ---- src/rad_alias_decoder.sv ----
// remote target alias decoder: alias and physical address registers, match and remap
//
// Chosen here: the strobed register port.
`include "rad_defines.svh"

module rad_alias_decoder (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    input  wire logic       txn_valid,
    input  wire logic [6:0] txn_addr,
    input  wire logic       txn_rnw,
    input  wire logic       fwd_lock,
    output logic            fwd_valid,
    output logic [6:0]      fwd_addr,
    output logic            fwd_rnw,
    input  wire logic       rsp_valid,
    input  wire logic       rsp_ack,
    output logic            ack_valid,
    output logic            ack,
    output logic            miss,
    output logic            busy
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    rad_pkg::rad_state_t s_q;
    rad_pkg::rad_state_t s_d;

    logic [`RAD_ENTRIES-1:0]      ent_hit;
    logic [`RAD_ENTRIES-1:0]      ent_fack;
    logic [`RAD_ENTRIES-1:0][6:0] ent_phys;
    logic                         any_hit;
    logic                         sel_fack;
    logic [6:0]                   sel_phys;
    logic                         in_alias;
    logic                         in_phys;
    logic [2:0]                   alias_idx;
    logic [2:0]                   phys_idx;

    ////////////////////////////////////////////////////////////////////////////////
    // per-entry compare

    for (genvar g = 0; g < `RAD_ENTRIES; g++) begin : g_ent
        rad_alias_entry u_ent (
            .alias_reg (s_q.alias_ent[g]),
            .phys_reg  (s_q.phys_ent[g]),
            .txn_addr  (txn_addr),
            .hit       (ent_hit[g]),
            .force_ack (ent_fack[g]),
            .phys_addr (ent_phys[g])
        );
    end

    // two entries with the same alias: the lowest index wins
    always_comb begin
        any_hit  = 1'b0;
        sel_fack = 1'b0;
        sel_phys = 7'h00;
        for (int i = `RAD_ENTRIES - 1; i >= 0; i--) begin
            if (ent_hit[i]) begin
                any_hit  = 1'b1;
                sel_fack = ent_fack[i];
                sel_phys = ent_phys[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    // one item per register: no subtraction, so an unmapped address never aliases an index
    always_comb begin
        in_alias  = 1'b0;
        in_phys   = 1'b0;
        alias_idx = 3'h0;
        phys_idx  = 3'h0;
        case (reg_addr)
            `RAD_ALIAS_OFS_0: begin
                in_alias  = 1'b1;
                alias_idx = 3'h0;
            end
            `RAD_ALIAS_OFS_1: begin
                in_alias  = 1'b1;
                alias_idx = 3'h1;
            end
            `RAD_ALIAS_OFS_2: begin
                in_alias  = 1'b1;
                alias_idx = 3'h2;
            end
            `RAD_ALIAS_OFS_3: begin
                in_alias  = 1'b1;
                alias_idx = 3'h3;
            end
            `RAD_ALIAS_OFS_4: begin
                in_alias  = 1'b1;
                alias_idx = 3'h4;
            end
            `RAD_ALIAS_OFS_5: begin
                in_alias  = 1'b1;
                alias_idx = 3'h5;
            end
            `RAD_PHYS_OFS_0: begin
                in_phys  = 1'b1;
                phys_idx = 3'h0;
            end
            `RAD_PHYS_OFS_1: begin
                in_phys  = 1'b1;
                phys_idx = 3'h1;
            end
            `RAD_PHYS_OFS_2: begin
                in_phys  = 1'b1;
                phys_idx = 3'h2;
            end
            `RAD_PHYS_OFS_3: begin
                in_phys  = 1'b1;
                phys_idx = 3'h3;
            end
            `RAD_PHYS_OFS_4: begin
                in_phys  = 1'b1;
                phys_idx = 3'h4;
            end
            `RAD_PHYS_OFS_5: begin
                in_phys  = 1'b1;
                phys_idx = 3'h5;
            end
            default: begin
                in_alias = 1'b0;
                in_phys  = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d           = s_q;
        s_d.rdata     = `RAD_RDATA_IDLE;
        s_d.fwd_valid = 1'b0;
        s_d.ack_valid = 1'b0;

        if (reg_wr) begin
            if (in_alias) begin
                s_d.alias_ent[alias_idx] = reg_wdata;
            end else if (in_phys) begin
                // bit 0 is reserved and kept at zero
                s_d.phys_ent[phys_idx] = {reg_wdata[7:1], 1'b0};
            end
        end

        // unmapped reads answer zero
        if (reg_rd) begin
            if (in_alias) begin
                s_d.rdata = s_q.alias_ent[alias_idx];
            end else if (in_phys) begin
                s_d.rdata = s_q.phys_ent[phys_idx];
            end
        end

        case (s_q.fsm)
            rad_pkg::RAD_IDLE: begin
                if (txn_valid) begin
                    if (!any_hit) begin
                        s_d.ack_valid = 1'b1;
                        s_d.ack       = 1'b0;
                        s_d.miss      = 1'b1;
                    end else if (sel_fack && !txn_rnw) begin
                        // forced ack answers at once; lock and remote answer do not matter
                        s_d.ack_valid = 1'b1;
                        s_d.ack       = 1'b1;
                        s_d.miss      = 1'b0;
                        if (fwd_lock) begin
                            s_d.fwd_valid = 1'b1;
                            s_d.fwd_addr  = sel_phys;
                            s_d.fwd_rnw   = txn_rnw;
                            s_d.fack_pend = 1'b1;
                            s_d.tmr       = '0;
                            s_d.busy      = 1'b1;
                            s_d.fsm       = rad_pkg::RAD_WAIT;
                        end
                    end else if (!fwd_lock) begin
                        // no forward link: nothing can answer, so refuse now
                        s_d.ack_valid = 1'b1;
                        s_d.ack       = 1'b0;
                        s_d.miss      = 1'b0;
                    end else begin
                        s_d.fwd_valid = 1'b1;
                        s_d.fwd_addr  = sel_phys;
                        s_d.fwd_rnw   = txn_rnw;
                        s_d.fack_pend = 1'b0;
                        s_d.miss      = 1'b0;
                        s_d.tmr       = '0;
                        s_d.busy      = 1'b1;
                        s_d.fsm       = rad_pkg::RAD_WAIT;
                    end
                end
            end
            rad_pkg::RAD_WAIT: begin
                s_d.tmr = s_q.tmr + `RAD_TMR_W'(1);
                if (rsp_valid) begin
                    s_d.fsm  = rad_pkg::RAD_IDLE;
                    s_d.busy = 1'b0;
                    // forced-ack answer was already given; the remote one is dropped
                    if (!s_q.fack_pend) begin
                        s_d.ack_valid = 1'b1;
                        s_d.ack       = rsp_ack;
                    end
                end else if (s_q.tmr == `RAD_TMR_W'(`RAD_RSP_TIMEOUT_CYC - 1)) begin
                    // a lost reply would otherwise hang the controller forever
                    s_d.fsm  = rad_pkg::RAD_IDLE;
                    s_d.busy = 1'b0;
                    if (!s_q.fack_pend) begin
                        s_d.ack_valid = 1'b1;
                        s_d.ack       = 1'b0;
                    end
                end
            end
            default: begin
                s_d.fsm  = rad_pkg::RAD_IDLE;
                s_d.busy = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q           <= '0;
            s_q.alias_ent <= {`RAD_ENTRIES{`RAD_ALIAS_RST}};
            s_q.phys_ent  <= {`RAD_ENTRIES{`RAD_PHYS_RST}};
            s_q.fsm       <= rad_pkg::RAD_IDLE;
            s_q.rdata     <= `RAD_RDATA_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign fwd_valid = s_q.fwd_valid;
    assign fwd_addr  = s_q.fwd_addr;
    assign fwd_rnw   = s_q.fwd_rnw;
    assign ack_valid = s_q.ack_valid;
    assign ack       = s_q.ack;
    assign miss      = s_q.miss;
    assign busy      = s_q.busy;

endmodule

// ---- src/rad_defines.svh ----
// register map, field positions, reset values and timing counts of the alias decoder
`ifndef RAD_DEFINES_SVH
`define RAD_DEFINES_SVH

`define RAD_ENTRIES         6
`define RAD_ALIAS_BASE      8'h41
`define RAD_ALIAS_LAST      8'h46
`define RAD_PHYS_BASE       8'h39
`define RAD_PHYS_LAST       8'h3e
`define RAD_ALIAS_OFS_0     8'h41
`define RAD_ALIAS_OFS_1     8'h42
`define RAD_ALIAS_OFS_2     8'h43
`define RAD_ALIAS_OFS_3     8'h44
`define RAD_ALIAS_OFS_4     8'h45
`define RAD_ALIAS_OFS_5     8'h46
`define RAD_PHYS_OFS_0      8'h39
`define RAD_PHYS_OFS_1      8'h3a
`define RAD_PHYS_OFS_2      8'h3b
`define RAD_PHYS_OFS_3      8'h3c
`define RAD_PHYS_OFS_4      8'h3d
`define RAD_PHYS_OFS_5      8'h3e
`define RAD_ADDR_MSB        7
`define RAD_ADDR_LSB        1
`define RAD_FACK_BIT        0
`define RAD_ALIAS_RST       8'h00
`define RAD_PHYS_RST        8'h00
`define RAD_NO_ALIAS        7'h00
`define RAD_RDATA_IDLE      8'h00

`define RAD_CLK_KHZ         10000
`define RAD_RSP_TIMEOUT_US  100
`define RAD_RSP_TIMEOUT_CYC ((`RAD_RSP_TIMEOUT_US * `RAD_CLK_KHZ) / 1000)
`define RAD_TMR_W           10

`endif

// ---- src/rad_pkg.sv ----
// types shared by the alias decoder files
package rad_pkg;
`include "rad_defines.svh"

    typedef enum logic [0:0] {
        RAD_IDLE,
        RAD_WAIT
    } rad_fsm_t;

    typedef struct packed {
        logic [`RAD_ENTRIES-1:0][7:0] alias_ent;
        logic [`RAD_ENTRIES-1:0][7:0] phys_ent;
        rad_fsm_t                     fsm;
        logic [`RAD_TMR_W-1:0]        tmr;
        logic                         fack_pend;
        logic                         busy;
        logic [7:0]                   rdata;
        logic                         fwd_valid;
        logic [6:0]                   fwd_addr;
        logic                         fwd_rnw;
        logic                         ack_valid;
        logic                         ack;
        logic                         miss;
    } rad_state_t;

endpackage

// ---- src/rad_alias_entry.sv ----
// one alias entry: compare, disable on zero alias, remap and forced-ack bit
`include "rad_defines.svh"

module rad_alias_entry (
    input  wire logic [7:0] alias_reg,
    input  wire logic [7:0] phys_reg,
    input  wire logic [6:0] txn_addr,
    output logic            hit,
    output logic            force_ack,
    output logic [6:0]      phys_addr
);

    logic [6:0] alias_addr_field;

    assign alias_addr_field = alias_reg[`RAD_ADDR_MSB:`RAD_ADDR_LSB];
    // zero alias never matches, so a cleared entry is simply off
    assign hit       = (alias_addr_field != `RAD_NO_ALIAS) && (alias_addr_field == txn_addr);
    assign force_ack = alias_reg[`RAD_FACK_BIT];
    assign phys_addr = phys_reg[`RAD_ADDR_MSB:`RAD_ADDR_LSB];

endmodule

// ---- test/rad_checker.sv ----
// port-level assertions for the alias decoder
module rad_checker (
    input wire logic       sys_clk,
    input wire logic       arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       txn_valid,
    input wire logic       txn_rnw,
    input wire logic       fwd_lock,
    input wire logic       fwd_valid,
    input wire logic       fwd_rnw,
    input wire logic       rsp_valid,
    input wire logic       rsp_ack,
    input wire logic       ack_valid,
    input wire logic       ack,
    input wire logic       miss,
    input wire logic       busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_wr_rd;
        reg_wr && reg_addr inside {[8'h41:8'h46]} ##2 reg_rd && reg_addr == $past(reg_addr, 2)
            |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("alias read back wrong");
    property p_txn_ans;
        txn_valid && !busy |=> ack_valid || fwd_valid;
    endproperty
    a_txn_ans: assert property (p_txn_ans) else $error("no answer to request");
    property p_miss;
        ack_valid && miss |-> !ack && !busy;
    endproperty
    a_miss: assert property (p_miss) else $error("miss not a nack");
    property p_no_lock;
        txn_valid && !busy && !fwd_lock |=> !fwd_valid && ack_valid;
    endproperty
    a_no_lock: assert property (p_no_lock) else $error("forwarded without lock");
    property p_fwd_rnw;
        txn_valid && !busy ##1 fwd_valid |-> fwd_rnw == $past(txn_rnw) && busy;
    endproperty
    a_fwd_rnw: assert property (p_fwd_rnw) else $error("forward direction wrong");
    property p_rsp_ack;
        busy && rsp_valid |=> !busy && (!ack_valid || ack == $past(rsp_ack));
    endproperty
    a_rsp_ack: assert property (p_rsp_ack) else $error("remote result lost");
    logic [10:0] busy_cnt_q;
    // cycles spent waiting; a delay range cannot span a whole timeout
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            busy_cnt_q <= 11'h000;
        else if (busy)
            busy_cnt_q <= busy_cnt_q + 11'h001;
        else
            busy_cnt_q <= 11'h000;
    end
    property p_busy_bound;
        busy_cnt_q <= 11'h3e8;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("busy stuck");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind rad_alias_decoder rad_checker u_chk (.*);

// ---- test/rad_remote_model.sv ----
// far-side model: answers forwarded requests after a set delay
module rad_remote_model (
    input wire logic       sys_clk,
    input wire logic       arst_n,
    input wire logic       fwd_valid,
    input wire logic [6:0] fwd_addr,
    input wire logic [3:0] dly,
    input wire logic [6:0] absent_addr,
    output logic           rsp_valid,
    output logic           rsp_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 4'h0;
            rsp_valid <= 1'b0;
            rsp_ack <= 1'b0;
        end else begin
            rsp_valid <= (cnt_q == 4'h1);
            // zero delay means silence, to force the timeout path
            if (fwd_valid && dly != 4'h0)
                cnt_q <= dly;
            else if (cnt_q != 4'h0)
                cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
                rsp_ack <= (fwd_addr != absent_addr);
            end else begin
                // toggles between answers so a stale value never looks valid
                rsp_ack <= ~rsp_ack;
            end
        end
    end
endmodule

// ---- test/testbench.sv ----
// register and transaction tests of the alias decoder
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, arst_n, reg_wr, reg_rd, txn_valid, txn_rnw, fwd_lock;
    logic rsp_valid, rsp_ack, fwd_valid, fwd_rnw, ack_valid, ack, miss, busy;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [6:0] txn_addr, fwd_addr;
    logic [3:0] dly;
    int errors, n_tests, n;
    rad_alias_decoder dut (.*);
    rad_remote_model u_rem (.sys_clk(sys_clk), .arst_n(arst_n), .fwd_valid(fwd_valid),
        .fwd_addr(fwd_addr), .dly(dly), .absent_addr(7'h25), .rsp_valid(rsp_valid),
        .rsp_ack(rsp_ack));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("errors %0d, comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata, e);
    endtask
    task automatic txn(input logic [6:0] a, input logic r, l, e_ack, e_miss);
        int i;
        for (i = 0; i < 1100 && busy !== 1'b0; i++) @(negedge sys_clk);
        if (busy !== 1'b0) begin
            errors++;
            end_sim;
        end
        @(posedge sys_clk);
        txn_valid <= 1'b1;
        txn_addr <= a;
        txn_rnw <= r;
        fwd_lock <= l;
        @(posedge sys_clk);
        txn_valid <= 1'b0;
        i = 0;
        do begin
            @(negedge sys_clk);
            i++;
        end while (ack_valid !== 1'b1 && i < 1100);
        if (i >= 1100) begin
            errors++;
            end_sim;
        end
        chk(ack, e_ack);
        chk(miss, e_miss);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {reg_wr, reg_rd, txn_valid, txn_rnw, fwd_lock} = 5'h00;
        {reg_addr, reg_wdata, txn_addr, dly} = {8'h00, 8'h00, 7'h00, 4'h3};
        arst_n = 1'b0;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (n = 0; n < 6; n++) rd(8'h41 + 8'(n), 8'h00);
        wr(8'h47, 8'hff);
        rd(8'h47, 8'h00);
        for (n = 0; n < 6; n++) begin
            wr(8'h41 + 8'(n), {7'h50 + 7'(n), 1'b0});
            rd(8'h41 + 8'(n), {7'h50 + 7'(n), 1'b0});
            wr(8'h39 + 8'(n), {7'h20 + 7'(n), 1'b1});
            rd(8'h39 + 8'(n), {7'h20 + 7'(n), 1'b0});
        end
        for (n = 0; n < 6; n++) begin
            txn(7'h50 + 7'(n), 1'b0, 1'b1, n != 5, 1'b0);
            chk(fwd_addr, 7'h20 + 7'(n));
        end
        txn(7'h51, 1'b1, 1'b0, 1'b0, 1'b0);
        // forced ack only for this debug pass
        wr(8'h46, 8'hab);
        rd(8'h46, 8'hab);
        txn(7'h55, 1'b0, 1'b0, 1'b1, 1'b0);
        txn(7'h55, 1'b0, 1'b1, 1'b1, 1'b0);
        txn(7'h55, 1'b1, 1'b1, 1'b0, 1'b0);
        wr(8'h46, 8'haa);
        txn(7'h55, 1'b0, 1'b1, 1'b0, 1'b0);
        wr(8'h42, 8'h01);
        txn(7'h00, 1'b0, 1'b1, 1'b0, 1'b1);
        txn(7'h51, 1'b0, 1'b1, 1'b0, 1'b1);
        @(posedge sys_clk);
        dly <= 4'h0;
        txn(7'h50, 1'b0, 1'b1, 1'b0, 1'b0);
        // second reset after the entries were written
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(8'h41, 8'h00);
        rd(8'h46, 8'h00);
        rd(8'h39, 8'h00);
        end_sim;
    end
endmodule
